// ==== hdl/cfp_port.sv ====
// Configuration port pin logic: flash fetch, chaining, peripheral strobes, address pins
//
// How it works
// - Active-high busy output stays high until configuration finishes.
// - Active-low busy output stays low until configuration finishes.
// - Flash command and address go out serially, changing on clock falling edges.
// - Standard flash mode sends 0x03 then a 24-bit start address.
// - Extended mode sends the power-up sampled instruction then 32 zero address bits.
// - Flash select goes low after init done rises, before serial clocking starts.
// - Flash select low at power-up, pulses high 100-200ns, extended instruction latched then.
// - Forwarding serial output passes all bits, preamble too, on clock rising edges.
// - In daisy mode stripped output skips preamble bits, updating on rising edges.
// - In parallel chain mode cascade enable goes low to pass data onward.
// - Read strobe low in peripheral mode turns data bits 7..3 into status outputs.
// - Host never asserts both strobes; if it does, the cycle is a write.
// - Selected with write strobe low loads the data byte into the buffer.
// - Selected only when low select is low and high select is high.
// - Master parallel mode drives the 22-bit address bus to configuration memory.
// - Host port address pins carry address 31..14, transfer size and burst flags.
// - Reset input resets the loader during configuration, then acts as GLOBAL_SET_RESET or input.
// - Interrupt output goes low on any bus error or host configuration error.
// - Host data width is 8, 16 or 32 bits with 1, 2 or 4 parity lanes.
`timescale 1ns/100ps
module cfp_port
  import cfp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input cfp_mode_e boot_mode,
  input cfp_width_e host_width,
  input wire logic config_clock,
  input wire logic init_done_n,
  input wire logic chip_reset_n,
  input wire logic config_done,
  input wire logic gsr_enable,
  input wire logic [23:0] start_addr,
  input cfp_bit_s chain_bit,
  input wire logic chain_pass,
  input wire logic status_read_n,
  input wire logic write_strobe_n,
  input wire logic select_low_n,
  input wire logic select_high,
  input wire logic [CFP_DATA_W-1:0] data_in,
  input wire logic [CFP_STAT_HI-CFP_STAT_LO:0] status_bits,
  input wire logic [CFP_ADDR_W-1:0] addr_in,
  input wire logic [CFP_ADDR_W-1:0] mem_addr,
  input wire logic bus_error,
  input wire logic host_cfg_error,
  output logic config_busy_high,
  output logic config_busy_low_n,
  output logic flash_si,
  output logic flash_select_n,
  output logic fetch_done,
  output logic serial_out,
  output logic stripped_serial_out,
  output logic cascade_enable_n,
  output logic [CFP_DATA_W-1:0] data_out,
  output logic [CFP_DATA_W-1:0] data_oe,
  output logic [CFP_DATA_W-1:0] wr_byte,
  output logic wr_byte_valid,
  output logic [CFP_ADDR_W-1:0] addr_out,
  output logic [CFP_ADDR_W-1:0] addr_oe,
  output cfp_host_s host_addr,
  output logic host_addr_valid,
  output logic [3:0] host_parity_lanes,
  output logic loader_reset,
  output logic global_set_reset,
  output logic user_reset_in,
  output logic config_irq_n
);
  localparam int SYNC_W = 7 + CFP_DATA_W + CFP_ADDR_W;

  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_SHIFT, ST_LOAD} cfp_state_e;

  // Two-stage synchroniser for the clock, init, reset, strobe, select, data and address pins and the boot mode
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  cfp_mode_e mode_meta_q;
  cfp_mode_e mode_q;
  logic sck_prev_q;
  logic init_prev_q;
  logic wr_prev_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      mode_meta_q <= CFP_M_SPI_STD;
      mode_q <= CFP_M_SPI_STD;
    end else begin
      // Init pin reads high once released, so its idle level after reset gives no false rise
      meta_q <= {config_clock, init_done_n, ~chip_reset_n, ~status_read_n, ~write_strobe_n,
                 ~select_low_n, select_high, data_in, addr_in};
      sync_q <= meta_q;
      mode_meta_q <= boot_mode;
      mode_q <= mode_meta_q;
    end
  end

  logic sck_s;
  logic init_s;
  logic rst_act;
  logic rd_s;
  logic wr_s;
  logic sel_lo_s;
  logic sel_hi_s;
  logic [CFP_DATA_W-1:0] d_s;
  logic [CFP_ADDR_W-1:0] a_s;
  logic wr_act;
  assign {sck_s, init_s, rst_act, rd_s, wr_s, sel_lo_s, sel_hi_s, d_s, a_s} = sync_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
      init_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      init_prev_q <= init_s;
      wr_prev_q <= wr_act;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic init_rise;
  logic selected;
  logic rd_act;
  logic spi_mode;
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign init_rise = init_s & ~init_prev_q;
  assign selected = sel_lo_s & sel_hi_s;
  assign wr_act = selected & wr_s;
  assign rd_act = selected & rd_s & ~wr_s;
  assign spi_mode = (mode_q == CFP_M_SPI_STD) || (mode_q == CFP_M_SPI_EXT);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      config_busy_high <= 1'b1;
      config_busy_low_n <= 1'b0;
    end else begin
      config_busy_high <= ~config_done;
      config_busy_low_n <= config_done;
    end
  end

  // Flash fetch sequencer
  cfp_state_e st_q;
  logic [5:0] cnt_q;
  logic [CFP_SHIFT_W-1:0] sh_q;
  logic [7:0] instr_q;
  logic [5:0] nbits;
  assign nbits = (mode_q == CFP_M_SPI_EXT) ? CFP_EXT_BITS : CFP_STD_BITS;

  always_ff @(posedge mclk) begin
    if (!rst_n || (rst_act && !config_done)) begin
      st_q <= ST_IDLE;
      cnt_q <= CFP_CNT_RST;
      sh_q <= '0;
      instr_q <= CFP_READ_CMD;
      flash_select_n <= 1'b0;
      flash_si <= 1'b0;
      fetch_done <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          // Select sits low until the init release, then pulses high
          if (init_rise && spi_mode) begin
            st_q <= ST_PULSE;
            flash_select_n <= 1'b1;
            cnt_q <= CFP_CNT_RST;
          end
        end
        ST_PULSE: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == CFP_PULSE_CYC - 6'h01) begin
            st_q <= ST_SHIFT;
            flash_select_n <= 1'b0;
            cnt_q <= CFP_CNT_RST;
            // Instruction sampled inside the pulse, data pins settled by then
            instr_q <= d_s;
            if (mode_q == CFP_M_SPI_EXT) begin
              sh_q <= {d_s, CFP_EXT_ADDR};
              flash_si <= d_s[7];
            end else begin
              sh_q <= {CFP_READ_CMD, start_addr, 8'h00};
              flash_si <= CFP_READ_CMD[7];
            end
          end
        end
        ST_SHIFT: begin
          if (sck_fall) begin
            sh_q <= {sh_q[CFP_SHIFT_W-2:0], 1'b0};
            flash_si <= sh_q[CFP_SHIFT_W-2];
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == nbits - 6'h01) begin
              st_q <= ST_LOAD;
              flash_si <= 1'b0;
              fetch_done <= 1'b1;
            end
          end
        end
        ST_LOAD: begin
          // Select stays low while the core streams the bitstream
          if (config_done) begin
            fetch_done <= 1'b0;
          end
        end
      endcase
    end
  end

  // Chain outputs: data outputs stepped by config clock rising edges, cascade enable updated every cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      serial_out <= 1'b0;
      stripped_serial_out <= 1'b0;
      cascade_enable_n <= 1'b1;
    end else begin
      if (sck_rise && chain_bit.valid) begin
        serial_out <= chain_bit.data;
        if (mode_q == CFP_M_DAISY && !chain_bit.preamble) begin
          stripped_serial_out <= chain_bit.data;
        end
      end
      cascade_enable_n <= ~((mode_q == CFP_M_PAR_CHAIN) && chain_pass);
    end
  end

  // Peripheral strobes and data pins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe <= '0;
      wr_byte <= '0;
      wr_byte_valid <= 1'b0;
    end else begin
      wr_byte_valid <= 1'b0;
      data_oe <= '0;
      data_out <= '0;
      if (wr_act && !wr_prev_q) begin
        wr_byte <= d_s;
        wr_byte_valid <= 1'b1;
      end
      if (rd_act && mode_q == CFP_M_ASYNC_PERIPH) begin
        data_oe[CFP_STAT_HI:CFP_STAT_LO] <= '1;
        data_out[CFP_STAT_HI:CFP_STAT_LO] <= status_bits;
      end
    end
  end

  // Address pins: driven in master parallel, decoded in host port mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_out <= '0;
      addr_oe <= '0;
      host_addr <= '0;
      host_addr_valid <= 1'b0;
      host_parity_lanes <= CFP_LANES_8;
    end else begin
      addr_out <= (mode_q == CFP_M_MASTER_PAR) ? mem_addr : '0;
      addr_oe <= (mode_q == CFP_M_MASTER_PAR) ? '1 : '0;
      host_addr_valid <= (mode_q == CFP_M_HOST_PORT) && selected;
      if (mode_q == CFP_M_HOST_PORT && selected) begin
        host_addr.addr_hi <= a_s[CFP_HA_HI:0];
        host_addr.size <= a_s[CFP_HSIZE_HI:CFP_HSIZE_LO];
        host_addr.burst_mode <= a_s[CFP_HBURST];
        host_addr.burst_active <= a_s[CFP_HBURST_ACT];
      end
      unique case (host_width)
        CFP_W8: host_parity_lanes <= CFP_LANES_8;
        CFP_W16: host_parity_lanes <= CFP_LANES_16;
        CFP_W32: host_parity_lanes <= CFP_LANES_32;
        default: host_parity_lanes <= CFP_LANES_8;
      endcase
    end
  end

  // Reset pin roles and interrupt request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loader_reset <= 1'b0;
      global_set_reset <= 1'b0;
      user_reset_in <= 1'b0;
      config_irq_n <= 1'b1;
    end else begin
      loader_reset <= rst_act && !config_done;
      global_set_reset <= rst_act && config_done && gsr_enable;
      user_reset_in <= rst_act && config_done && !gsr_enable;
      config_irq_n <= ~(bus_error | host_cfg_error);
    end
  end

  // Checking helpers
  localparam int ASRT_PULSE = CFP_PULSE_CYC_I;
  int sel_hi_cnt;
  always_ff @(posedge mclk) begin
    if (!rst_n || !flash_select_n) begin
      sel_hi_cnt <= 0;
    end else begin
      sel_hi_cnt <= sel_hi_cnt + 1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_busy_high;
    !config_done |=> config_busy_high;
  endproperty
  a_busy_high: assert property (p_busy_high) else $error("busy high not held");

  property p_busy_low;
    !config_done |=> !config_busy_low_n;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy low not held");

  property p_si_on_fall;
    (st_q == ST_SHIFT && $past(st_q) == ST_SHIFT && $changed(flash_si)) |-> $past(sck_fall);
  endproperty
  a_si_on_fall: assert property (p_si_on_fall) else $error("serial data moved off a falling edge");

  property p_std_cmd;
    ($rose(st_q == ST_SHIFT) && mode_q == CFP_M_SPI_STD) |-> sh_q[CFP_SHIFT_W-1 -: 8] == CFP_READ_CMD
      && flash_si == CFP_READ_CMD[7];
  endproperty
  a_std_cmd: assert property (p_std_cmd) else $error("standard read command wrong");

  property p_ext_cmd;
    ($rose(st_q == ST_SHIFT) && mode_q == CFP_M_SPI_EXT) |-> sh_q[CFP_SHIFT_W-9:0] == CFP_EXT_ADDR
      && sh_q[CFP_SHIFT_W-1 -: 8] == instr_q;
  endproperty
  a_ext_cmd: assert property (p_ext_cmd) else $error("extended instruction or address wrong");

  property p_select_before_clk;
    st_q == ST_SHIFT |-> !flash_select_n;
  endproperty
  a_select_before_clk: assert property (p_select_before_clk) else $error("shifting without select");

  property p_pulse_len;
    // A reset pin abort cuts the pulse short on purpose
    ($fell(flash_select_n) && $past(st_q) == ST_PULSE && !$past(rst_act)) |-> $past(sel_hi_cnt) == ASRT_PULSE - 1;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("select pulse length wrong");

  property p_dout_follow;
    (sck_rise && chain_bit.valid) |=> serial_out == $past(chain_bit.data);
  endproperty
  a_dout_follow: assert property (p_dout_follow) else $error("forwarding output missed a bit");

  property p_strip_preamble;
    (sck_rise && chain_bit.valid && chain_bit.preamble) |=> $stable(stripped_serial_out);
  endproperty
  a_strip_preamble: assert property (p_strip_preamble) else $error("preamble bit leaked");

  property p_cascade;
    (mode_q == CFP_M_PAR_CHAIN && chain_pass) |=> !cascade_enable_n;
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade enable not driven");

  property p_read_status;
    (rd_act && mode_q == CFP_M_ASYNC_PERIPH) |=> data_oe == 8'hF8 && data_out[7:3] == $past(status_bits);
  endproperty
  a_read_status: assert property (p_read_status) else $error("status not driven on read");

  property p_write_wins;
    (wr_act && rd_s) |=> data_oe == 8'h00;
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("read drove pins during write");

  property p_unselected;
    !selected |=> !wr_byte_valid;
  endproperty
  a_unselected: assert property (p_unselected) else $error("write taken while unselected");

  property p_master_addr;
    mode_q == CFP_M_MASTER_PAR |=> addr_oe == '1 && addr_out == $past(mem_addr);
  endproperty
  a_master_addr: assert property (p_master_addr) else $error("address bus not driven");

  property p_loader_reset;
    (rst_act && !config_done) |=> st_q == ST_IDLE && loader_reset;
  endproperty
  a_loader_reset: assert property (p_loader_reset) else $error("loader not reset");

  property p_irq;
    (bus_error || host_cfg_error) |=> !config_irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_fetch_done: cover property ($rose(fetch_done));
  c_ext_fetch: cover property ($rose(fetch_done) && mode_q == CFP_M_SPI_EXT);
  c_write_byte: cover property (wr_byte_valid);
  c_status_read: cover property (data_oe != 8'h00);
endmodule

// ==== pkg/cfp_pkg.sv ====
// Constants, modes and carriers of the configuration port pin logic
package cfp_pkg;
  localparam int CFP_CLK_NS = 4;
  localparam int CFP_PULSE_MIN_NS = 100;
  localparam int CFP_PULSE_MAX_NS = 200;
  localparam int CFP_PULSE_CYC_I = (CFP_PULSE_MIN_NS + CFP_CLK_NS - 1) / CFP_CLK_NS;
  localparam logic [5:0] CFP_PULSE_CYC = 6'(CFP_PULSE_CYC_I);
  localparam logic [7:0] CFP_READ_CMD = 8'h03;
  localparam int CFP_INSTR_BITS = 8;
  localparam int CFP_STD_ADDR_BITS = 24;
  localparam int CFP_EXT_ADDR_BITS = 32;
  localparam int CFP_SHIFT_W = CFP_INSTR_BITS + CFP_EXT_ADDR_BITS;
  localparam logic [5:0] CFP_STD_BITS = 6'(CFP_INSTR_BITS + CFP_STD_ADDR_BITS);
  localparam logic [5:0] CFP_EXT_BITS = 6'(CFP_SHIFT_W);
  localparam logic [23:0] CFP_STD_ADDR_RST = 24'h000000;
  localparam logic [31:0] CFP_EXT_ADDR = 32'h00000000;
  localparam int CFP_ADDR_W = 22;
  localparam int CFP_DATA_W = 8;
  localparam int CFP_STAT_LO = 3;
  localparam int CFP_STAT_HI = 7;
  // Host port field positions on the address pins
  localparam int CFP_HA_HI = 17;
  localparam int CFP_HSIZE_LO = 18;
  localparam int CFP_HSIZE_HI = 19;
  localparam int CFP_HBURST = 20;
  localparam int CFP_HBURST_ACT = 21;
  localparam logic [3:0] CFP_LANES_8 = 4'h1;
  localparam logic [3:0] CFP_LANES_16 = 4'h3;
  localparam logic [3:0] CFP_LANES_32 = 4'hF;
  localparam logic [5:0] CFP_CNT_RST = 6'h00;

  typedef enum logic [2:0] {
    CFP_M_SPI_STD, CFP_M_SPI_EXT, CFP_M_MASTER_PAR, CFP_M_ASYNC_PERIPH,
    CFP_M_HOST_PORT, CFP_M_DAISY, CFP_M_PAR_CHAIN
  } cfp_mode_e;

  typedef enum logic [1:0] {CFP_W8, CFP_W16, CFP_W32} cfp_width_e;

  typedef struct packed {
    logic valid;
    logic data;
    logic preamble;
  } cfp_bit_s;

  typedef struct packed {
    logic [CFP_HA_HI:0] addr_hi;
    logic [1:0] size;
    logic burst_mode;
    logic burst_active;
  } cfp_host_s;
endpackage

// ==== testbench/cfp_flash_model.sv ====
// Serial flash partner that records the fetch command and address
`timescale 1ns/100ps
module cfp_flash_model (
  input wire logic sck,
  input wire logic select_n,
  input wire logic si,
  output logic [39:0] rx_bits,
  output int rx_count
);
  // Fresh frame whenever the select goes away; sample on the rising clock, device shifts on the falling one
  always @(posedge sck or posedge select_n) begin
    if (select_n) begin
      rx_bits = '0;
      rx_count = 0;
    end else begin
      rx_bits = {rx_bits[38:0], si};
      rx_count = rx_count + 1;
    end
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the configuration port pin logic
`timescale 1ns/100ps
module tb;
  import cfp_pkg::*;
  logic mclk = 0, rst_n = 0, config_clock = 0, init_done_n = 0, chip_reset_n = 1, config_done = 0;
  logic gsr_enable = 0, chain_pass = 0, status_read_n = 1, write_strobe_n = 1, select_low_n = 1;
  logic select_high = 0, bus_error = 0, host_cfg_error = 0;
  cfp_mode_e boot_mode = CFP_M_SPI_STD;
  cfp_width_e host_width = CFP_W8;
  cfp_bit_s chain_bit = '0;
  logic [23:0] start_addr = 24'h000000;
  logic [7:0] data_in = 8'h00;
  logic [4:0] status_bits = 5'h00;
  logic [21:0] addr_in = 22'h000000, mem_addr = 22'h000000;
  logic config_busy_high, config_busy_low_n, flash_si, flash_select_n, fetch_done, serial_out;
  logic stripped_serial_out, cascade_enable_n, wr_byte_valid, host_addr_valid, loader_reset;
  logic global_set_reset, user_reset_in, config_irq_n;
  logic [7:0] data_out, data_oe, wr_byte;
  logic [21:0] addr_out, addr_oe;
  logic [3:0] host_parity_lanes;
  cfp_host_s host_addr;
  logic [39:0] rx_bits;
  int rx_count, num_errors = 0, checks = 0, cycles = 0;

  cfp_port DUT (.mclk, .rst_n, .boot_mode, .host_width, .config_clock, .init_done_n, .chip_reset_n,
    .config_done, .gsr_enable, .start_addr, .chain_bit, .chain_pass, .status_read_n, .write_strobe_n,
    .select_low_n, .select_high, .data_in, .status_bits, .addr_in, .mem_addr, .bus_error, .host_cfg_error,
    .config_busy_high, .config_busy_low_n, .flash_si, .flash_select_n, .fetch_done, .serial_out,
    .stripped_serial_out, .cascade_enable_n, .data_out, .data_oe, .wr_byte, .wr_byte_valid, .addr_out,
    .addr_oe, .host_addr, .host_addr_valid, .host_parity_lanes, .loader_reset, .global_set_reset,
    .user_reset_in, .config_irq_n);
  cfp_flash_model FLASH (.sck(config_clock), .select_n(flash_select_n), .si(flash_si), .rx_bits, .rx_count);

  always #2 mclk = ~mclk;

  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Two fetches take about 2500 cycles; the rest is short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic do_reset;
    rst_n = 0;
    cyc(6);
    rst_n = 1;
    cyc(3);
  endtask

  // Link clock only runs inside a frame, 125 ns period
  task automatic sck_pulses(input int n);
    repeat (n) begin
      #62.5 config_clock = 1;
      #62.5 config_clock = 0;
    end
  endtask

  task automatic wait_select_high;
    int n;
    n = 0;
    while (flash_select_n !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic t_abort;
    init_done_n = 1;
    wait_select_high();
    cyc(5);
    chip_reset_n = 0;
    cyc(6);
    check("abort_select", flash_select_n, 0);
    check("loader_reset", loader_reset, 1);
    chip_reset_n = 1;
    init_done_n = 0;
  endtask

  task automatic t_fetch(input bit ext, input logic [23:0] addr, input logic [7:0] instr);
    int n;
    int hi;
    logic [39:0] exp;
    boot_mode = ext ? CFP_M_SPI_EXT : CFP_M_SPI_STD;
    start_addr = addr;
    data_in = instr;
    do_reset();
    init_done_n = 1;
    wait_select_high();
    hi = 0;
    while (flash_select_n === 1'b1 && hi < 60) begin
      cyc(1);
      hi++;
    end
    check("pulse_len", hi, CFP_PULSE_MIN_NS / CFP_CLK_NS);
    check("select_pre_sck", flash_select_n, 0);
    n = ext ? 40 : 32;
    exp = ext ? {instr, 32'h00000000} : {16'h0003, addr};
    sck_pulses(n);
    cyc(4);
    check("rx_count", rx_count, n);
    check("rx_bits", rx_bits, exp);
    check("fetch_done", fetch_done, 1);
    check("select_after", flash_select_n, 0);
    init_done_n = 0;
  endtask

  task automatic chain_step(input logic d, input logic pre, input logic exp_strip);
    chain_bit = '{valid: 1'b1, data: d, preamble: pre};
    sck_pulses(1);
    cyc(3);
    check("serial_out", serial_out, d);
    check("stripped", stripped_serial_out, exp_strip);
  endtask

  task automatic t_chain;
    boot_mode = CFP_M_DAISY;
    cyc(4);
    chain_step(1, 0, 1);
    chain_step(0, 1, 1);
    chain_step(0, 0, 0);
    chain_bit.data = 1;
    cyc(4);
    check("no_rise", serial_out, 0);
    boot_mode = CFP_M_PAR_CHAIN;
    chain_pass = 1;
    cyc(4);
    check("cascade_on", cascade_enable_n, 0);
    chain_pass = 0;
    cyc(3);
    check("cascade_off", cascade_enable_n, 1);
  endtask

  task automatic strobe(input logic sl, sh, rd, wr, input int exp_p, input logic [7:0] exp_oe);
    int p;
    logic [7:0] got;
    p = 0;
    got = 8'h00;
    select_low_n = sl;
    select_high = sh;
    status_read_n = rd;
    write_strobe_n = wr;
    repeat (8) begin
      @(negedge mclk);
      if (wr_byte_valid === 1'b1) begin
        p++;
        got = wr_byte;
      end
    end
    check("wr_pulses", p, exp_p);
    check("data_oe", data_oe, exp_oe);
    if (exp_p > 0) check("wr_byte", got, data_in);
    if (exp_oe != 8'h00) check("status", data_out[7:3], status_bits);
    status_read_n = 1;
    write_strobe_n = 1;
    select_low_n = 1;
    select_high = 0;
    cyc(4);
    check("oe_release", data_oe, 0);
  endtask

  task automatic t_periph;
    boot_mode = CFP_M_ASYNC_PERIPH;
    status_bits = 5'h15;
    data_in = 8'hA5;
    strobe(0, 1, 1, 0, 1, 8'h00);
    strobe(1, 1, 1, 0, 0, 8'h00);
    strobe(0, 0, 1, 0, 0, 8'h00);
    strobe(1, 1, 0, 1, 0, 8'h00);
    strobe(0, 1, 0, 1, 0, 8'hF8);
    // Host misuses both strobes on purpose here
    strobe(0, 1, 0, 0, 1, 8'h00);
  endtask

  task automatic t_addr;
    boot_mode = CFP_M_MASTER_PAR;
    mem_addr = 22'h2A5C3F;
    cyc(4);
    check("addr_oe", addr_oe, 22'h3FFFFF);
    check("addr_out", addr_out, mem_addr);
    boot_mode = CFP_M_HOST_PORT;
    select_low_n = 0;
    select_high = 1;
    addr_in = {1'b1, 1'b0, 2'b01, 18'h2ABCD};
    cyc(5);
    check("host_addr", host_addr, {18'h2ABCD, 2'b01, 1'b0, 1'b1});
    check("host_valid", host_addr_valid, 1);
    check("host_addr_oe", addr_oe, 0);
    select_low_n = 1;
    select_high = 0;
    for (int i = 0; i < 3; i++) begin
      host_width = cfp_width_e'(i);
      cyc(3);
      check("lanes", host_parity_lanes, (5'h01 << (1 << i)) - 5'h01);
    end
  endtask

  task automatic t_irq_done;
    bus_error = 1;
    cyc(2);
    check("irq_bus", config_irq_n, 0);
    bus_error = 0;
    host_cfg_error = 1;
    cyc(2);
    check("irq_cfg", config_irq_n, 0);
    host_cfg_error = 0;
    cyc(2);
    check("irq_clear", config_irq_n, 1);
    check("busy_before", {config_busy_high, config_busy_low_n}, 2'b10);
    config_done = 1;
    cyc(2);
    check("busy_after", {config_busy_high, config_busy_low_n}, 2'b01);
    gsr_enable = 1;
    chip_reset_n = 0;
    cyc(5);
    check("gsr", global_set_reset, 1);
    check("no_loader_reset", loader_reset, 0);
    gsr_enable = 0;
    cyc(2);
    check("user_reset", user_reset_in, 1);
    check("gsr_off", global_set_reset, 0);
    chip_reset_n = 1;
  endtask

  initial begin
    do_reset();
    check("rst_busy", {config_busy_high, config_busy_low_n}, 2'b10);
    check("rst_select", flash_select_n, 0);
    t_abort();
    t_fetch(0, 24'h5A0C81, 8'h00);
    t_fetch(1, 24'h000000, 8'h6B);
    t_chain();
    t_periph();
    t_addr();
    t_irq_done();
    finish_test();
  end
endmodule
